// *** rtl/dag_pkg.sv ***
`default_nettype none
package dag_pkg;
	localparam int ADDR_W      = 14;          // address width of both memory spaces
	localparam int DATA_W      = 16;          // register width
	localparam int PM_W        = 24;          // program memory word width
	localparam int EXT_W       = 8;           // width of the pm_extension field
	localparam int NUM_PTR     = 4;           // pointers per generator
	localparam int SEL_W       = 2;           // select width for pointers and steps
	localparam int EXT_LSB     = 0;           // extension occupies the low byte
	localparam logic [ADDR_W-1:0] PTR_RST  = 14'h0000; // pointer reset value
	localparam logic [ADDR_W-1:0] STEP_RST = 14'h0000; // step reset value
	localparam logic [ADDR_W-1:0] SPAN_RST = 14'h0000; // span reset value: linear
	localparam logic [EXT_W-1:0]  EXT_RST  = 8'h00;    // pm_extension reset value

	// which register file a load targets
	typedef enum logic [1:0]
	{
		LOAD_PTR  = 2'b00,
		LOAD_STEP = 2'b01,
		LOAD_SPAN = 2'b11
	} load_kind_e;

	// memory space selected by the second generator
	typedef enum logic
	{
		SPACE_DATA = 1'b0,
		SPACE_PROG = 1'b1
	} space_e;
endpackage
`default_nettype wire

// *** rtl/addr_gen_unit.sv ***
`default_nettype none
// ---------------------------------------------------------------
// one address generator: four pointers, four steps, four spans
// ---------------------------------------------------------------
module addr_gen_unit
	import dag_pkg::*;
#(
	parameter bit HAS_REVERSE = 1'b0          // bit reversal present
)
(
	input  wire logic              i_clk,       // cycle clock
	input  wire logic              i_rst,       // synchronous reset
	input  wire logic              i_access,    // indirect access, post-modify
	input  wire logic [SEL_W-1:0]  i_ptr_sel,   // pointer in use
	input  wire logic [SEL_W-1:0]  i_step_sel,  // step register to add
	input  wire logic              i_reverse,   // bit-reversed output
	input  wire logic              i_load,      // register load strobe
	input  wire load_kind_e        i_load_kind, // register file to load
	input  wire logic [SEL_W-1:0]  i_load_sel,  // register index to load
	input  wire logic [ADDR_W-1:0] i_load_val,  // value to load
	output logic [ADDR_W-1:0]      o_addr       // address for this cycle
);
	logic [ADDR_W-1:0] ptr_reg  [NUM_PTR];
	logic [ADDR_W-1:0] step_reg [NUM_PTR];
	logic [ADDR_W-1:0] span_reg [NUM_PTR];
	logic [ADDR_W-1:0] ptr_next  [NUM_PTR];
	logic [ADDR_W-1:0] step_next [NUM_PTR];
	logic [ADDR_W-1:0] span_next [NUM_PTR];
	logic [ADDR_W-1:0] cur_addr;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [ADDR_W-1:0] bit_rev(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] r;
		for (int k = 0; k < ADDR_W; k++)
		begin
			r[k] = a[ADDR_W-1-k];
		end
		return r;
	endfunction

	// base is span-aligned low bound; wrap on either boundary, span zero is linear
	function automatic logic [ADDR_W-1:0] post_mod(input logic [ADDR_W-1:0] p,
		input logic [ADDR_W-1:0] m, input logic [ADDR_W-1:0] l);
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] res;
		logic [ADDR_W-1:0] nxt;
		base = '0;
		res  = p + m;                                     // carry out dropped on purpose
		nxt  = res;
		if (l != '0)
		begin
			base = p - (p % l);
			if (m[ADDR_W-1])                             // negative step
			begin
				if (res < base || res > p)
					nxt = ADDR_W'(res + l);
			end
			else if (res >= ADDR_W'(base + l) || res < p)
			begin
				nxt = ADDR_W'(res - l);
			end
		end
		return nxt;
	endfunction

	// ---------------------------------------------------------------
	// next-state for the register files
	// ---------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < NUM_PTR; i++)
		begin
			ptr_next[i]  = ptr_reg[i];
			step_next[i] = step_reg[i];
			span_next[i] = span_reg[i];
		end
		// post-modify lands in the same cycle as the address, no stall
		if (i_access)
			ptr_next[i_ptr_sel] = post_mod(ptr_reg[i_ptr_sel],
				step_reg[i_step_sel], span_reg[i_ptr_sel]);
		// an explicit load wins over the post-modify of the same pointer
		if (i_load)
		begin
			unique case (i_load_kind)
				LOAD_PTR:  ptr_next[i_load_sel]  = i_load_val;
				LOAD_STEP: step_next[i_load_sel] = i_load_val;
				LOAD_SPAN: span_next[i_load_sel] = i_load_val;
				default:   ;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		for (int i = 0; i < NUM_PTR; i++)
		begin
			ptr_reg[i]  <= i_rst ? PTR_RST  : ptr_next[i];
			step_reg[i] <= i_rst ? STEP_RST : step_next[i];
			span_reg[i] <= i_rst ? SPAN_RST : span_next[i];
		end
	end

	// address is the pre-modify pointer, reversed only where fitted
	always_comb
	begin
		cur_addr = ptr_reg[i_ptr_sel];
		if (HAS_REVERSE && i_reverse)
			cur_addr = bit_rev(ptr_reg[i_ptr_sel]);
		o_addr = cur_addr;
	end

	a_linear_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_access && !i_load && span_reg[i_ptr_sel] == '0) |=>
		ptr_reg[$past(i_ptr_sel)] == ADDR_W'($past(ptr_reg[i_ptr_sel])
			+ $past(step_reg[i_step_sel])))
		else $error("linear post-modify wrong");
	a_wrap_inside: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_access && !i_load && span_reg[i_ptr_sel] != '0
			&& step_reg[i_step_sel] < span_reg[i_ptr_sel]
			&& !step_reg[i_step_sel][ADDR_W-1]) |=>
		(ptr_reg[$past(i_ptr_sel)] - ($past(ptr_reg[i_ptr_sel])
			- $past(ptr_reg[i_ptr_sel]) % $past(span_reg[i_ptr_sel])))
			< $past(span_reg[i_ptr_sel]))
		else $error("circular pointer left buffer");
	a_plain_addr: assert property (@(posedge i_clk) disable iff (i_rst)
		(!HAS_REVERSE || !i_reverse) |-> o_addr == ptr_reg[i_ptr_sel])
		else $error("address altered without reversal");
endmodule
`default_nettype wire

// *** rtl/data_address_generators.sv ***
`default_nettype none
module data_address_generators
	import dag_pkg::*;
(
	input  wire logic              I_CLOCK,          // processor cycle clock
	input  wire logic              I_RST,            // synchronous reset, high
	input  wire logic              i_dg_access,      // data-only generator access
	input  wire logic [SEL_W-1:0]  i_dg_ptr_sel,     // its pointer
	input  wire logic [SEL_W-1:0]  i_dg_step_sel,    // its step register
	input  wire logic              i_dg_reverse,     // bit-reverse its address
	input  wire logic              i_ds_access,      // dual-space generator access
	input  wire logic [SEL_W-1:0]  i_ds_ptr_sel,     // its pointer
	input  wire logic [SEL_W-1:0]  i_ds_step_sel,    // its step register
	input  wire space_e            i_ds_space,       // its target memory space
	input  wire logic              i_sp_access,      // serial port auto transfer
	input  wire logic [SEL_W-1:0]  i_sp_ptr_sel,     // serial port pointer
	input  wire logic [SEL_W-1:0]  i_sp_step_sel,    // serial port step
	input  wire logic              i_load_dg,        // load into data-only unit
	input  wire logic              i_load_ds,        // load into dual-space unit
	input  wire load_kind_e        i_load_kind,      // which register file
	input  wire logic [SEL_W-1:0]  i_load_sel,       // register index
	input  wire logic [ADDR_W-1:0] i_load_val,       // load value
	input  wire logic              i_pm_write,       // 16-bit write to program memory
	input  wire logic              i_pm_read,        // data read from program memory
	input  wire logic [DATA_W-1:0] i_reg_data,       // register value to write
	input  wire logic [PM_W-1:0]   i_pm_rdata,       // program memory read word
	input  wire logic              i_ext_load,       // direct pm_extension load
	input  wire logic [EXT_W-1:0]  i_ext_val,        // its value
	output logic [ADDR_W-1:0]      o_dm_addr,        // data memory address
	output logic                   o_dm_valid,       // data memory access
	output logic [ADDR_W-1:0]      o_pm_addr,        // program memory address
	output logic                   o_pm_valid,       // program memory access
	output logic [PM_W-1:0]        o_pm_wdata,       // program memory write word
	output logic                   o_pm_wr,          // program memory write strobe
	output logic [DATA_W-1:0]      o_reg_data,       // upper 16 bits of read word
	output logic [EXT_W-1:0]       o_pm_extension    // pm_extension contents
);
	logic [ADDR_W-1:0] dg_addr;
	logic [ADDR_W-1:0] ds_addr;
	logic              dg_go;
	logic [SEL_W-1:0]  dg_ptr;
	logic [SEL_W-1:0]  dg_step;
	logic              ds_dm;
	logic [ADDR_W-1:0] dm_addr_next, dm_addr_reg;
	logic [ADDR_W-1:0] pm_addr_next, pm_addr_reg;
	logic              dm_valid_next, dm_valid_reg;
	logic              pm_valid_next, pm_valid_reg;
	logic [PM_W-1:0]   wdata_next, wdata_reg;
	logic              wr_next, wr_reg;
	logic [DATA_W-1:0] rdata_next, rdata_reg;
	logic [EXT_W-1:0]  ext_next, ext_reg;

	// ---------------------------------------------------------------
	// generators
	// ---------------------------------------------------------------
	// serial port borrows the data-only unit when the core leaves it idle
	// limitation: a serial transfer in a cycle the core also uses is dropped
	always_comb
	begin
		dg_go   = i_dg_access | i_sp_access;
		dg_ptr  = i_dg_access ? i_dg_ptr_sel  : i_sp_ptr_sel;
		dg_step = i_dg_access ? i_dg_step_sel : i_sp_step_sel;
	end

	addr_gen_unit #(.HAS_REVERSE(1'b1)) u_data_only_addr_gen
	(
		.i_clk       (I_CLOCK),
		.i_rst       (I_RST),
		.i_access    (dg_go),
		.i_ptr_sel   (dg_ptr),
		.i_step_sel  (dg_step),
		.i_reverse   (i_dg_reverse & i_dg_access),
		.i_load      (i_load_dg),
		.i_load_kind (i_load_kind),
		.i_load_sel  (i_load_sel),
		.i_load_val  (i_load_val),
		.o_addr      (dg_addr)
	);

	addr_gen_unit #(.HAS_REVERSE(1'b0)) u_dual_space_addr_gen
	(
		.i_clk       (I_CLOCK),
		.i_rst       (I_RST),
		.i_access    (i_ds_access),
		.i_ptr_sel   (i_ds_ptr_sel),
		.i_step_sel  (i_ds_step_sel),
		.i_reverse   (1'b0),
		.i_load      (i_load_ds),
		.i_load_kind (i_load_kind),
		.i_load_sel  (i_load_sel),
		.i_load_val  (i_load_val),
		.o_addr      (ds_addr)
	);

	// ---------------------------------------------------------------
	// address buses and program memory transfer path
	// ---------------------------------------------------------------
	// a data-space request on the dual-space unit only uses the data bus
	// when the data-only unit is idle; otherwise the data-only unit wins
	// the read capture comes last so it beats a direct extension load
	always_comb
	begin
		ds_dm         = i_ds_access && (i_ds_space == SPACE_DATA);
		dm_valid_next = dg_go | ds_dm;
		dm_addr_next  = dg_go ? dg_addr : ds_addr;
		pm_valid_next = i_ds_access && (i_ds_space == SPACE_PROG);
		pm_addr_next  = ds_addr;
		wr_next       = i_pm_write;
		wdata_next    = {i_reg_data, ext_reg};
		rdata_next    = i_pm_read ? i_pm_rdata[PM_W-1:EXT_W] : rdata_reg;
		ext_next      = ext_reg;
		if (i_ext_load)
			ext_next = i_ext_val;
		if (i_pm_read)
			ext_next = i_pm_rdata[EXT_LSB +: EXT_W];
	end

	// register every output so both buses see clean edges
	always_ff @(posedge I_CLOCK)
	begin
		if (I_RST)
		begin
			dm_addr_reg  <= PTR_RST;
			pm_addr_reg  <= PTR_RST;
			dm_valid_reg <= 1'b0;
			pm_valid_reg <= 1'b0;
			wdata_reg    <= '0;
			wr_reg       <= 1'b0;
			rdata_reg    <= '0;
			ext_reg      <= EXT_RST;
		end
		else
		begin
			dm_addr_reg  <= dm_addr_next;
			pm_addr_reg  <= pm_addr_next;
			dm_valid_reg <= dm_valid_next;
			pm_valid_reg <= pm_valid_next;
			wdata_reg    <= wdata_next;
			wr_reg       <= wr_next;
			rdata_reg    <= rdata_next;
			ext_reg      <= ext_next;
		end
	end

	// outputs come straight from the flip-flops
	assign o_dm_addr      = dm_addr_reg;
	assign o_dm_valid     = dm_valid_reg;
	assign o_pm_addr      = pm_addr_reg;
	assign o_pm_valid     = pm_valid_reg;
	assign o_pm_wdata     = wdata_reg;
	assign o_pm_wr        = wr_reg;
	assign o_reg_data     = rdata_reg;
	assign o_pm_extension = ext_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_ext_low_byte: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		i_pm_write |=> o_pm_wr && o_pm_wdata[EXT_W-1:0] == $past(ext_reg)
			&& o_pm_wdata[PM_W-1:EXT_W] == $past(i_reg_data))
		else $error("program write low byte not from extension");
	a_ext_capture: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		i_pm_read |=> o_pm_extension == $past(i_pm_rdata[EXT_W-1:0]))
		else $error("extension not loaded on program read");
	a_dual_fetch: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(i_dg_access && i_ds_access && i_ds_space == SPACE_PROG) |=>
		o_dm_valid && o_pm_valid)
		else $error("dual operand fetch not issued together");
	a_one_cycle: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(i_dg_access && !i_dg_reverse) |=> o_dm_addr == $past(dg_addr))
		else $error("address not issued next cycle");
	a_no_reverse: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(i_ds_access && i_ds_space == SPACE_PROG) |=> o_pm_addr == $past(ds_addr))
		else $error("dual-space address altered");
	a_serial_path: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(i_sp_access && !i_dg_access) |=> o_dm_valid)
		else $error("serial port transfer not addressed");

	// the data bus may be shared, the program bus belongs to the dual-space unit
	a_ds_data: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(i_ds_access && i_ds_space == SPACE_DATA && !dg_go) |=>
		o_dm_valid && !o_pm_valid && o_dm_addr == $past(ds_addr))
		else $error("dual-space data access not on data bus");
	a_dg_data_only: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(dg_go && !i_ds_access) |=> o_dm_valid && !o_pm_valid)
		else $error("data-only access reached program bus");
	a_idle_quiet: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!dg_go && !i_ds_access) |=> !o_dm_valid && !o_pm_valid)
		else $error("address strobe without access");
	a_dm_hidden: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(dg_go && i_ds_access && i_ds_space == SPACE_DATA) |=>
		o_dm_addr == $past(dg_addr))
		else $error("data bus not given to data-only unit");

	// program memory transfer path
	a_wr_pulse: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		!i_pm_write |=> !o_pm_wr)
		else $error("program write strobe without request");
	a_ext_direct: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(i_ext_load && !i_pm_read) |=> o_pm_extension == $past(i_ext_val))
		else $error("direct extension load lost");
	a_reg_upper: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		i_pm_read |=> o_reg_data == $past(i_pm_rdata[PM_W-1:EXT_W]))
		else $error("upper word bits not loaded on program read");
	a_ext_hold: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!i_ext_load && !i_pm_read) |=> $stable(o_pm_extension))
		else $error("extension changed with no load");

	// ---------------------------------------------------------------
	// scenario covers
	// ---------------------------------------------------------------
	c_dual: cover property (@(posedge I_CLOCK) i_dg_access && i_ds_access);
	c_rev: cover property (@(posedge I_CLOCK) i_dg_access && i_dg_reverse);
	c_pm_rw: cover property (@(posedge I_CLOCK) i_pm_write ##[1:10] i_pm_read);
	c_serial: cover property (@(posedge I_CLOCK) i_sp_access && !i_dg_access);
	c_ext_race: cover property (@(posedge I_CLOCK) i_pm_read && i_ext_load);
endmodule
`default_nettype wire

// *** verification/pm_memory_model.sv ***
`default_nettype none
// ------------------------------------------------------------
// program memory on the far side of the address and data buses
// ------------------------------------------------------------
module pm_memory_model
	import dag_pkg::*;
(
	input  wire logic              i_clk,   // cycle clock
	input  wire logic [ADDR_W-1:0] i_addr,  // program address
	input  wire logic              i_valid, // access this cycle
	input  wire logic [PM_W-1:0]   i_wdata, // word to store
	input  wire logic              i_wr,    // store strobe
	output logic [PM_W-1:0]        o_rdata  // read word, one cycle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [PM_W-1:0] mem [2**ADDR_W];
	logic [PM_W-1:0] rd_reg = 24'h00_0000;
	// every word starts with its own address in the upper 14 bits, so a wrong fetch shows up
	initial
	begin
		for (int a = 0; a < 2**ADDR_W; a++)
		begin
			mem[a] = {ADDR_W'(a), 10'h3C5};
		end
	end
	// word stands one cycle only; afterwards the bus toggles, never holds
	always @(posedge i_clk)
	begin
		if (i_valid && i_wr)
			mem[i_addr] <= i_wdata;
		if (i_valid && !i_wr)
			rd_reg <= mem[i_addr];
		else
			rd_reg <= ~rd_reg;
	end
	assign o_rdata = rd_reg;
endmodule
`default_nettype wire

// *** verification/data_address_generators_bench.sv ***
`default_nettype none
module data_address_generators_bench import dag_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic I_CLOCK = 1'b0, I_RST = 1'b1, i_dg_access = 1'b0, i_dg_reverse = 1'b0;
	logic i_ds_access = 1'b0, i_sp_access = 1'b0, i_load_dg = 1'b0, i_load_ds = 1'b0;
	logic i_pm_write = 1'b0, i_pm_read = 1'b0, i_ext_load = 1'b0;
	logic [SEL_W-1:0] i_dg_ptr_sel = '0, i_dg_step_sel = '0, i_ds_ptr_sel = '0;
	logic [SEL_W-1:0] i_ds_step_sel = '0, i_sp_ptr_sel = '0, i_sp_step_sel = '0, i_load_sel = '0;
	space_e i_ds_space = SPACE_DATA;
	load_kind_e i_load_kind = LOAD_PTR;
	logic [ADDR_W-1:0] i_load_val = '0, o_dm_addr, o_pm_addr;
	logic [DATA_W-1:0] i_reg_data = '0, o_reg_data;
	logic [EXT_W-1:0] i_ext_val = '0, o_pm_extension;
	logic [PM_W-1:0] i_pm_rdata, o_pm_wdata;
	logic o_dm_valid, o_pm_valid, o_pm_wr;
	int n_mismatch = 0;
	int checked = 0;

	always #4 I_CLOCK = ~I_CLOCK;

	data_address_generators uut (.I_CLOCK, .I_RST, .i_dg_access, .i_dg_ptr_sel, .i_dg_step_sel,
		.i_dg_reverse, .i_ds_access, .i_ds_ptr_sel, .i_ds_step_sel, .i_ds_space, .i_sp_access,
		.i_sp_ptr_sel, .i_sp_step_sel, .i_load_dg, .i_load_ds, .i_load_kind, .i_load_sel,
		.i_load_val, .i_pm_write, .i_pm_read, .i_reg_data, .i_pm_rdata, .i_ext_load, .i_ext_val,
		.o_dm_addr, .o_dm_valid, .o_pm_addr, .o_pm_valid, .o_pm_wdata, .o_pm_wr, .o_reg_data,
		.o_pm_extension);

	pm_memory_model partner (.i_clk(I_CLOCK), .i_addr(o_pm_addr), .i_valid(o_pm_valid),
		.i_wdata(o_pm_wdata), .i_wr(o_pm_wr), .o_rdata(i_pm_rdata));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task print_verdict();
		$display("comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task check(input bit ok, input string msg);
		checked++;
		if (!ok)
		begin
			n_mismatch++;
			$display("wrong value at %0t ns: %s", $time, msg);
		end
	endtask

	// one register load; strobe lowered at the taking edge
	task load(input logic dg, input load_kind_e k, input logic [1:0] s, input logic [13:0] v);
		@(posedge I_CLOCK);
		i_load_dg <= dg;
		i_load_ds <= !dg;
		i_load_kind <= k;
		i_load_sel <= s;
		i_load_val <= v;
		@(posedge I_CLOCK);
		i_load_dg <= 1'b0;
		i_load_ds <= 1'b0;
	endtask

	// all three requesters share one select pair to keep the call short
	task drive(input logic dg, ds, sp, rev, input space_e k, input logic [1:0] p, s);
		i_dg_access <= dg;
		i_ds_access <= ds;
		i_sp_access <= sp;
		i_dg_reverse <= rev;
		i_ds_space <= k;
		{i_dg_ptr_sel, i_ds_ptr_sel, i_sp_ptr_sel} <= {3{p}};
		{i_dg_step_sel, i_ds_step_sel, i_sp_step_sel} <= {3{s}};
	endtask

	// back-to-back accesses, one expected data address per cycle
	task burst(input bit sp, input logic [1:0] p, s, input logic rev, input int n,
		input logic [13:0] e [4]);
		@(posedge I_CLOCK);
		drive(!sp, 1'b0, sp, rev, SPACE_DATA, p, s);
		for (int k = 0; k < n; k++)
		begin
			@(posedge I_CLOCK);
			if (k == n - 1)
				drive(1'b0, 1'b0, 1'b0, 1'b0, SPACE_DATA, p, s);
			#1;
			check(o_dm_valid === 1'b1 && o_dm_addr === e[k], "data address");
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_linear();
		load(1'b1, LOAD_PTR, 2'd0, 14'h0005);
		load(1'b1, LOAD_STEP, 2'd0, 14'h0002);
		load(1'b1, LOAD_STEP, 2'd2, 14'h3FFE);
		load(1'b1, LOAD_PTR, 2'd1, 14'h0100);
		burst(1'b0, 2'd0, 2'd0, 1'b0, 3, '{14'h0005, 14'h0007, 14'h0009, 14'h0000});
		burst(1'b0, 2'd1, 2'd2, 1'b0, 2, '{14'h0100, 14'h00FE, 14'h0000, 14'h0000});
		burst(1'b0, 2'd0, 2'd0, 1'b0, 1, '{14'h000B, 14'h0000, 14'h0000, 14'h0000});
	endtask

	// span 5 on a block at 0x14: leaves through the top, then the bottom
	task t_circ();
		load(1'b1, LOAD_PTR, 2'd2, 14'h0014);
		load(1'b1, LOAD_STEP, 2'd1, 14'h0003);
		load(1'b1, LOAD_SPAN, 2'd2, 14'h0005);
		burst(1'b0, 2'd2, 2'd1, 1'b0, 4, '{14'h0014, 14'h0017, 14'h0015, 14'h0018});
		burst(1'b0, 2'd2, 2'd2, 1'b0, 3, '{14'h0016, 14'h0014, 14'h0017, 14'h0000});
	endtask

	task t_rev();
		load(1'b1, LOAD_PTR, 2'd3, 14'h0003);
		burst(1'b0, 2'd3, 2'd0, 1'b1, 2, '{14'h3000, 14'h2800, 14'h0000, 14'h0000});
	endtask

	// both spaces in one cycle, then the second unit alone with reversal asked
	task t_dual();
		load(1'b1, LOAD_PTR, 2'd1, 14'h0200);
		load(1'b0, LOAD_PTR, 2'd1, 14'h0040);
		load(1'b0, LOAD_STEP, 2'd0, 14'h0001);
		@(posedge I_CLOCK);
		drive(1'b1, 1'b1, 1'b0, 1'b0, SPACE_PROG, 2'd1, 2'd0);
		@(posedge I_CLOCK);
		drive(1'b0, 1'b1, 1'b0, 1'b1, SPACE_DATA, 2'd1, 2'd0);
		#1;
		check(o_dm_valid === 1'b1 && o_dm_addr === 14'h0200 && o_pm_valid === 1'b1
			&& o_pm_addr === 14'h0040, "dual fetch");
		@(posedge I_CLOCK);
		drive(1'b0, 1'b0, 1'b0, 1'b0, SPACE_DATA, 2'd1, 2'd0);
		#1;
		check(o_dm_valid === 1'b1 && o_dm_addr === 14'h0041 && o_pm_valid === 1'b0, "space");
	endtask

	// write packs the extension low; read capture beats a direct load
	task t_pm();
		logic [PM_W-1:0] word;
		word = {14'h0042, 10'h3C5};
		@(posedge I_CLOCK);
		i_ext_load <= 1'b1;
		i_ext_val <= 8'hA5;
		@(posedge I_CLOCK);
		i_ext_load <= 1'b0;
		i_pm_write <= 1'b1;
		i_reg_data <= 16'h1234;
		@(posedge I_CLOCK);
		i_pm_write <= 1'b0;
		#1;
		check(o_pm_wr === 1'b1 && o_pm_wdata === 24'h12_34A5, "write word");
		@(posedge I_CLOCK);
		drive(1'b0, 1'b1, 1'b0, 1'b0, SPACE_PROG, 2'd1, 2'd0);
		@(posedge I_CLOCK);
		drive(1'b0, 1'b0, 1'b0, 1'b0, SPACE_DATA, 2'd1, 2'd0);
		@(posedge I_CLOCK);
		i_pm_read <= 1'b1;
		i_ext_load <= 1'b1;
		i_ext_val <= 8'h5A;
		@(posedge I_CLOCK);
		i_pm_read <= 1'b0;
		i_ext_load <= 1'b0;
		#1;
		check(o_reg_data === word[23:8] && o_pm_extension === word[7:0], "read split");
	endtask

	task t_serial();
		load(1'b1, LOAD_PTR, 2'd0, 14'h0030);
		load(1'b1, LOAD_SPAN, 2'd0, 14'h0003);
		load(1'b1, LOAD_STEP, 2'd3, 14'h0001);
		burst(1'b1, 2'd0, 2'd3, 1'b0, 4, '{14'h0030, 14'h0031, 14'h0032, 14'h0030});
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge I_CLOCK);
		I_RST <= 1'b0;
		#1;
		check(o_dm_valid === 1'b0 && o_pm_wr === 1'b0 && o_pm_extension === 8'h00, "reset");
		t_linear();
		t_circ();
		t_rev();
		t_dual();
		t_pm();
		t_serial();
		print_verdict();
	end

	// whole run is about 70 cycles; 1000 leaves ample margin
	initial
	begin
		repeat (1000) @(posedge I_CLOCK);
		n_mismatch++;
		print_verdict();
	end
endmodule
`default_nettype wire
